//--- tb/panel_monitor_select_tb.sv
`timescale 1ns/10ps
module panel_monitor_select_tb;
    import pms_pkg::*;
    logic        clk_i, rst_n_i, panel_in_use_i, monitor_cycle_key_i, running_i, fault_i;
    logic        output_shutoff_input_i, opt_in_fitted_i, opt_out_fitted_i, hz_led_o;
    logic        seg_middle_o, press, prev, kp = 0, fp = 0;
    logic [1:0]  hold;
    logic [3:0]  dp_o;
    logic [7:0]  panel_monitor_select_setting_i, sel;
    logic [15:0] set_freq_raw_i, out_freq_i, current_i, voltage_i, other_value_i, max_freq_i;
    logic [15:0] min_freq_i, base_in_i, base_out_i, opt_in_i, opt_out_i, value_o;
    logic [15:0] seg_upper_o, seg_lower_o, eu, el, lat = 16'h0000;
    logic [47:0] jump_lo_i, jump_hi_i;
    logic [31:0] r;
    pms_pos_t    pos_o, ep = PMS_POS_FIRST;
    pms_item_t   item_o;
    logic [15:0] jl [3] = '{16'h0400, 16'h0800, 16'h1000};
    logic [15:0] jh [3] = '{16'h0500, 16'h0900, 16'h1100};
    logic [7:0]  sels [7] = '{8'h00, 8'h37, 8'h38, 8'h39, 8'h64, 8'h05, 8'h14};
    integer      seed = 33890;
    int          err_total = 0, checks = 0, cyc = 0, tog = 0;

    pms_top #(.BLINK_CYC(4)) dut_u (
        .clk_i                          (clk_i),
        .rst_n_i                        (rst_n_i),
        .panel_monitor_select_setting_i (panel_monitor_select_setting_i),
        .panel_in_use_i                 (panel_in_use_i),
        .monitor_cycle_key_i            (monitor_cycle_key_i),
        .running_i                      (running_i),
        .output_shutoff_input_i         (output_shutoff_input_i),
        .fault_i                        (fault_i),
        .set_freq_raw_i                 (set_freq_raw_i),
        .out_freq_i                     (out_freq_i),
        .current_i                      (current_i),
        .voltage_i                      (voltage_i),
        .other_value_i                  (other_value_i),
        .max_freq_i                     (max_freq_i),
        .min_freq_i                     (min_freq_i),
        .jump_lo_i                      (jump_lo_i),
        .jump_hi_i                      (jump_hi_i),
        .base_in_i                      (base_in_i),
        .base_out_i                     (base_out_i),
        .opt_in_i                       (opt_in_i),
        .opt_out_i                      (opt_out_i),
        .opt_in_fitted_i                (opt_in_fitted_i),
        .opt_out_fitted_i               (opt_out_fitted_i),
        .pos_o                          (pos_o),
        .item_o                         (item_o),
        .value_o                        (value_o),
        .hz_led_o                       (hz_led_o),
        .seg_upper_o                    (seg_upper_o),
        .seg_lower_o                    (seg_lower_o),
        .seg_middle_o                   (seg_middle_o),
        .dp_o                           (dp_o)
    );
    pms_panel_model pan_u (.clk_i(clk_i), .press_i(press), .hold_i(hold),
        .key_o(monitor_cycle_key_i));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Limits come first; a value strictly inside a skip band then drops to its lower edge.
    function automatic logic [15:0] lim(input logic [15:0] v);
        logic [15:0] x;
        x = v > 16'h1770 ? 16'h1770 : (v < 16'h0100 ? 16'h0100 : v);
        for (int k = 0; k < 3; k++) begin
            if (x > jl[k] && x < jh[k])
                x = jl[k];
        end
        return x;
    endfunction

    // Inputs still hold what the last rising edge sampled, so the expectation uses them.
    task automatic step;
        @(negedge clk_i);
        sel = panel_monitor_select_setting_i;
        if (fault_i && !fp)
            lat = out_freq_i;
        fp = fault_i;
        case (ep)
            PMS_POS_FIRST: if (sel == 8'h64 && !fault_i
                               && (!running_i || output_shutoff_input_i)) begin
                chk(item_o, PMS_ITEM_SETFREQ);
                chk(value_o, lim(set_freq_raw_i));
            end else begin
                chk(item_o, PMS_ITEM_OUTFREQ);
                chk(value_o, fault_i ? lat : out_freq_i);
                if (sel == 8'h64 && !fault_i)
                    chk(16'(hz_led_o), 16'h0001);
            end
            PMS_POS_SECOND: chk(value_o, current_i);
            PMS_POS_THIRD: if (sel inside {8'h37, 8'h38, 8'h39}) begin
                eu = sel == 8'h38 && opt_in_fitted_i ? opt_in_i : 16'h0000;
                el = sel == 8'h39 && opt_out_fitted_i ? opt_out_i : 16'h0000;
                chk(seg_upper_o, sel == 8'h37 ? base_in_i : eu);
                chk(seg_lower_o, sel == 8'h37 ? base_out_i : el);
                chk(16'(seg_middle_o), 16'h0001);
                chk(16'(dp_o), {14'h0000, sel == 8'h39, sel == 8'h38});
            end else if (sel == 8'h05) begin
                chk(item_o, PMS_ITEM_RAWSET);
                chk(value_o, set_freq_raw_i);
            end else if (sel == 8'h14 && panel_in_use_i) begin
                chk(item_o, PMS_ITEM_OTHER);
                chk(value_o, other_value_i);
            end else begin
                chk(item_o, PMS_ITEM_VOLTAGE);
                chk(value_o, voltage_i);
            end
            default: chk(value_o, lat);
        endcase
        if (monitor_cycle_key_i && !kp)
            ep = pms_pos_t'(ep + 2'h1);
        kp = monitor_cycle_key_i;
        chk(pos_o, ep);
    endtask

    always @(posedge clk_i) begin
        cyc = cyc + 1;
        if (cyc == 4000) begin
            err_total = err_total + 1;
            print_verdict();
        end
    end

    initial begin
        {rst_n_i, press, hold, running_i, output_shutoff_input_i, fault_i, opt_in_fitted_i,
         opt_out_fitted_i, base_in_i, base_out_i, opt_in_i, opt_out_i} = '0;
        {panel_monitor_select_setting_i, panel_in_use_i} = {8'h64, 1'b1};
        {set_freq_raw_i, out_freq_i, current_i, voltage_i, other_value_i} = {5{16'h0480}};
        {max_freq_i, min_freq_i} = {16'h1770, 16'h0100};
        {jump_lo_i, jump_hi_i} = {jl[2], jl[1], jl[0], jh[2], jh[1], jh[0]};
        repeat (8) @(posedge clk_i);
        @(negedge clk_i);
        chk(pos_o, PMS_POS_FIRST);
        chk(value_o, 16'h0000);
        rst_n_i = 1'b1;
        repeat (24) begin
            prev = hz_led_o;
            step();
            tog = tog + int'(hz_led_o !== prev);
        end
        chk(16'(tog > 2 && tog < 9), 16'h0001);
        repeat (3000) begin
            step();
            r = $random(seed);
            {press, hold} <= r[2:0];
            {running_i, panel_in_use_i, opt_in_fitted_i, opt_out_fitted_i} = r[6:3];
            output_shutoff_input_i = &r[8:7];
            fault_i = &r[11:9];
            if (r[14:12] == 3'h0)
                panel_monitor_select_setting_i = sels[r[17:15] % 7];
            {base_in_i, base_out_i} = $random(seed);
            {opt_in_i, opt_out_i} = $random(seed);
            {out_freq_i, current_i} = $random(seed);
            {voltage_i, other_value_i} = $random(seed);
            set_freq_raw_i = 16'({$random(seed)} % 6400);
        end
        // Reset again with the key released, so no held press meets a cleared edge detector.
        press <= 1'b0;
        repeat (8) @(negedge clk_i);
        rst_n_i = 1'b0;
        ep = PMS_POS_FIRST;
        kp = 1'b0;
        fp = 1'b0;
        lat = 16'h0000;
        @(negedge clk_i);
        chk(pos_o, PMS_POS_FIRST);
        chk(item_o, PMS_ITEM_OUTFREQ);
        rst_n_i = 1'b1;
        repeat (60) step();
        print_verdict();
    end
endmodule // panel_monitor_select_tb

//--- tb/pms_panel_model.sv
`timescale 1ns/10ps
module pms_panel_model (
    input  wire logic       clk_i,
    input  wire logic       press_i,
    input  wire logic [1:0] hold_i,
    output logic            key_o
);
    int cnt = 0;
    // A press lasts two to five cycles and is always followed by a released cycle.
    initial key_o = 1'b0;
    always @(negedge clk_i) begin
        if (cnt != 0)
            cnt = cnt - 1;
        else if (press_i)
            cnt = hold_i + 3;
        key_o <= cnt > 1;
    end
endmodule // pms_panel_model

//--- tb/pms_top_assertions.sv
`timescale 1ns/10ps
module pms_chk #(
    parameter int unsigned W = 16
) (
    input  wire logic               clk_i,
    input  wire logic               rst_n_i,
    input  wire logic [7:0]         panel_monitor_select_setting_i,
    input  wire logic               running_i,
    input  wire logic               output_shutoff_input_i,
    input  wire logic               fault_i,
    input  wire logic               monitor_cycle_key_i,
    input  wire logic [W-1:0]       out_freq_i,
    input  wire pms_pkg::pms_pos_t  pos_o,
    input  wire pms_pkg::pms_item_t item_o,
    input  wire logic [W-1:0]       value_o,
    input  wire logic               hz_led_o,
    input  wire logic               seg_middle_o,
    input  wire logic [3:0]         dp_o
);
    import pms_pkg::*;
    wire logic [7:0] sel  = panel_monitor_select_setting_i;
    wire logic       stop = !running_i || output_shutoff_input_i;
    wire logic       sp   = pos_o == PMS_POS_FIRST && sel == 8'h64 && !fault_i;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_key_adv; $rose(monitor_cycle_key_i) |=>
        pos_o == pms_pos_t'($past(pos_o) + 2'h1); endproperty
    a_key_adv: assert property (p_key_adv) else $error("key press did not step");
    property p_key_hold; !$rose(monitor_cycle_key_i) |=> $stable(pos_o); endproperty
    a_key_hold: assert property (p_key_hold) else $error("position moved unbidden");
    property p_run; sp && !stop |=> item_o == PMS_ITEM_OUTFREQ && hz_led_o &&
        value_o == $past(out_freq_i); endproperty
    a_run: assert property (p_run) else $error("running display wrong");
    property p_stop; sp && stop |=> item_o == PMS_ITEM_SETFREQ; endproperty
    a_stop: assert property (p_stop) else $error("stopped display wrong");
    property p_second; pos_o == PMS_POS_SECOND |=> item_o == PMS_ITEM_CURRENT; endproperty
    a_second: assert property (p_second) else $error("second item wrong");
    property p_mid; pos_o == PMS_POS_THIRD && sel inside {8'h37, 8'h38, 8'h39} |=>
        seg_middle_o && item_o == PMS_ITEM_TERMINAL; endproperty
    a_mid: assert property (p_mid) else $error("terminal mode wrong");
    property p_dp56; pos_o == PMS_POS_THIRD && sel == 8'h38 |=> dp_o == 4'h1; endproperty
    a_dp56: assert property (p_dp56) else $error("first point wrong");
    property p_dp57; pos_o == PMS_POS_THIRD && sel == 8'h39 |=> dp_o == 4'h2; endproperty
    a_dp57: assert property (p_dp57) else $error("second point wrong");
    c_term: cover property (item_o == PMS_ITEM_TERMINAL);
    c_set: cover property (item_o == PMS_ITEM_SETFREQ);
    c_fault: cover property (pos_o == PMS_POS_FAULT && fault_i);
endmodule // pms_chk

bind pms_top pms_chk #(.W(W)) chk_u (.clk_i, .rst_n_i, .panel_monitor_select_setting_i,
    .running_i, .output_shutoff_input_i, .fault_i, .monitor_cycle_key_i, .out_freq_i,
    .pos_o, .item_o, .value_o, .hz_led_o, .seg_middle_o, .dp_o);

//--- verilog/pms_freq_limit.sv
`timescale 1ns/10ps
module pms_freq_limit #(
    parameter int unsigned W = pms_pkg::FREQ_W,
    parameter int unsigned N = pms_pkg::JUMP_N
) (
    input  wire logic [W-1:0]   raw_i,
    input  wire logic [W-1:0]   max_i,
    input  wire logic [W-1:0]   min_i,
    input  wire logic [N*W-1:0] jump_lo_i,
    input  wire logic [N*W-1:0] jump_hi_i,
    output logic      [W-1:0]   lim_o
);
    import pms_pkg::*;

    // Clamp, then pull any value inside a jump band down to its lower edge.
    always_comb begin
        logic [W-1:0] v;
        v = raw_i;
        if (v > max_i) begin
            v = max_i;
        end
        if (v < min_i) begin
            v = min_i;
        end
        for (int k = 0; k < N; k++) begin
            if (v > jump_lo_i[k*W +: W] && v < jump_hi_i[k*W +: W]) begin
                v = jump_lo_i[k*W +: W];
            end
        end
        lim_o = v;
    end
endmodule // pms_freq_limit

//--- verilog/pms_pkg.sv
// Summary of operation
// - Select 100 shows set frequency when stopped, output frequency when running.
// - Select 100 blinks the Hz indicator when stopped, steady when running.
// - Stopped value under 100 is the limited, jump-skipped frequency, not raw.
// - During a fault the output frequency latched at fault onset is shown.
// - With output shutoff asserted the display matches the stopped state.
// - The selected monitor item occupies the third monitor position.
// - The first monitor position is shown right after power-up.
// - Select 0 on the panel shows frequency, current, voltage and fault items.
// - Select 55 to 57 renders a terminal-state monitor in position three.
// - Each terminal segment is lit exactly while its terminal is active.
// - The middle horizontal segment stays lit in every terminal mode.
// - Select 55 puts base inputs on upper segments, outputs on lower.
// - Selects 56 and 57 work without the option card; segments then off.
// - Select 56 lights the first digit decimal point continuously.
// - Select 57 lights the second digit decimal point.
package pms_pkg;
    localparam int unsigned FREQ_W      = 16;
    localparam int unsigned SEL_W       = 8;
    localparam int unsigned TERM_W      = 16;
    localparam logic [7:0]  SEL_VOLTAGE = 8'h00;
    localparam logic [7:0]  SEL_RAWSET  = 8'h05;
    localparam logic [7:0]  SEL_TERM_U  = 8'h37;
    localparam logic [7:0]  SEL_TERM_OI = 8'h38;
    localparam logic [7:0]  SEL_TERM_OO = 8'h39;
    localparam logic [7:0]  SEL_SETSTOP = 8'h64;
    localparam int unsigned JUMP_N      = 3;
    localparam int unsigned BLINK_MS    = 250;
    localparam int unsigned CLK_KHZ     = 250000;
    localparam int unsigned BLINK_CYC   = BLINK_MS * CLK_KHZ;
    localparam int unsigned DIG_N       = 4;

    typedef enum logic [1:0] {
        PMS_POS_FIRST,
        PMS_POS_SECOND,
        PMS_POS_THIRD,
        PMS_POS_FAULT
    } pms_pos_t;

    typedef enum logic [2:0] {
        PMS_ITEM_OUTFREQ,
        PMS_ITEM_SETFREQ,
        PMS_ITEM_RAWSET,
        PMS_ITEM_CURRENT,
        PMS_ITEM_VOLTAGE,
        PMS_ITEM_TERMINAL,
        PMS_ITEM_FAULT,
        PMS_ITEM_OTHER
    } pms_item_t;
endpackage

//--- verilog/pms_term_map.sv
`timescale 1ns/10ps
module pms_term_map #(
    parameter int unsigned TW = pms_pkg::TERM_W
) (
    input  wire logic [7:0]       sel_i,
    input  wire logic [TW-1:0]    base_in_i,
    input  wire logic [TW-1:0]    base_out_i,
    input  wire logic [TW-1:0]    opt_in_i,
    input  wire logic [TW-1:0]    opt_out_i,
    input  wire logic             opt_in_fitted_i,
    input  wire logic             opt_out_fitted_i,
    output logic      [TW-1:0]    upper_o,
    output logic      [TW-1:0]    lower_o,
    output logic                  middle_o,
    output logic      [3:0]       dp_o
);
    import pms_pkg::*;

    // Option monitors put one terminal group on one row: option inputs upper, option outputs lower.
    always_comb begin
        upper_o  = '0;
        lower_o  = '0;
        dp_o     = 4'h0;
        middle_o = 1'b1;
        case (sel_i)
            SEL_TERM_U: begin
                upper_o = base_in_i;
                lower_o = base_out_i;
            end
            SEL_TERM_OI: begin
                dp_o[0] = 1'b1;
                if (opt_in_fitted_i) begin
                    upper_o = opt_in_i;
                end
            end
            SEL_TERM_OO: begin
                dp_o[1] = 1'b1;
                if (opt_out_fitted_i) begin
                    lower_o = opt_out_i;
                end
            end
            default: begin
                middle_o = 1'b0;
            end
        endcase
    end
endmodule // pms_term_map

//--- verilog/pms_top.sv
`timescale 1ns/10ps
module pms_top #(
    parameter int unsigned W          = pms_pkg::FREQ_W,
    parameter int unsigned TW         = pms_pkg::TERM_W,
    parameter int unsigned N          = pms_pkg::JUMP_N,
    parameter int unsigned BLINK_CYC  = pms_pkg::BLINK_CYC
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    input  wire logic [7:0]            panel_monitor_select_setting_i,
    input  wire logic                  panel_in_use_i,
    input  wire logic                  monitor_cycle_key_i,
    input  wire logic                  running_i,
    input  wire logic                  output_shutoff_input_i,
    input  wire logic                  fault_i,
    input  wire logic [W-1:0]          set_freq_raw_i,
    input  wire logic [W-1:0]          out_freq_i,
    input  wire logic [W-1:0]          current_i,
    input  wire logic [W-1:0]          voltage_i,
    input  wire logic [W-1:0]          other_value_i,
    input  wire logic [W-1:0]          max_freq_i,
    input  wire logic [W-1:0]          min_freq_i,
    input  wire logic [N*W-1:0]        jump_lo_i,
    input  wire logic [N*W-1:0]        jump_hi_i,
    input  wire logic [TW-1:0]         base_in_i,
    input  wire logic [TW-1:0]         base_out_i,
    input  wire logic [TW-1:0]         opt_in_i,
    input  wire logic [TW-1:0]         opt_out_i,
    input  wire logic                  opt_in_fitted_i,
    input  wire logic                  opt_out_fitted_i,
    output pms_pkg::pms_pos_t          pos_o,
    output pms_pkg::pms_item_t         item_o,
    output logic      [W-1:0]          value_o,
    output logic                       hz_led_o,
    output logic      [TW-1:0]         seg_upper_o,
    output logic      [TW-1:0]         seg_lower_o,
    output logic                       seg_middle_o,
    output logic      [3:0]            dp_o
);
    import pms_pkg::*;

    pms_pos_t    pos_q;
    pms_item_t   item_d;
    logic        key_q;
    logic        fault_q;
    logic [W-1:0] fault_freq_q;
    logic [W-1:0] fault_freq;
    logic [W-1:0] set_lim;
    logic [W-1:0] value_d;
    logic [31:0] blink_cnt_q;
    logic        blink_q;
    logic        stopped;
    logic        term_sel;
    logic [TW-1:0] up_d;
    logic [TW-1:0] lo_d;
    logic        mid_d;
    logic [3:0]  dp_d;

    pms_freq_limit #(
        .W (W),
        .N (N)
    ) u_limit (
        .raw_i     (set_freq_raw_i),
        .max_i     (max_freq_i),
        .min_i     (min_freq_i),
        .jump_lo_i (jump_lo_i),
        .jump_hi_i (jump_hi_i),
        .lim_o     (set_lim)
    );

    pms_term_map #(
        .TW (TW)
    ) u_term (
        .sel_i            (panel_monitor_select_setting_i),
        .base_in_i        (base_in_i),
        .base_out_i       (base_out_i),
        .opt_in_i         (opt_in_i),
        .opt_out_i        (opt_out_i),
        .opt_in_fitted_i  (opt_in_fitted_i),
        .opt_out_fitted_i (opt_out_fitted_i),
        .upper_o          (up_d),
        .lower_o          (lo_d),
        .middle_o         (mid_d),
        .dp_o             (dp_d)
    );

    // Output shutoff coasts the motor, so the panel treats it as a stop.
    assign stopped  = !running_i || output_shutoff_input_i;
    assign term_sel = (panel_monitor_select_setting_i == SEL_TERM_U)
                   || (panel_monitor_select_setting_i == SEL_TERM_OI)
                   || (panel_monitor_select_setting_i == SEL_TERM_OO);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            key_q <= 1'b0;
            pos_q <= PMS_POS_FIRST;
        end else begin
            key_q <= monitor_cycle_key_i;
            if (monitor_cycle_key_i && !key_q) begin
                case (pos_q)
                    PMS_POS_FIRST:  pos_q <= PMS_POS_SECOND;
                    PMS_POS_SECOND: pos_q <= PMS_POS_THIRD;
                    PMS_POS_THIRD:  pos_q <= PMS_POS_FAULT;
                    default:        pos_q <= PMS_POS_FIRST;
                endcase
            end
        end
    end

    // The frequency is captured on the rising edge of the fault only.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fault_q      <= 1'b0;
            fault_freq_q <= '0;
        end else begin
            fault_q <= fault_i;
            if (fault_i && !fault_q) begin
                fault_freq_q <= out_freq_i;
            end
        end
    end

    // At fault onset the register still holds the old capture, so bypass it for that cycle.
    assign fault_freq = (fault_i && !fault_q) ? out_freq_i : fault_freq_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            blink_cnt_q <= '0;
            blink_q     <= 1'b0;
        end else if (blink_cnt_q >= BLINK_CYC - 1) begin
            blink_cnt_q <= '0;
            blink_q     <= !blink_q;
        end else begin
            blink_cnt_q <= blink_cnt_q + 32'h1;
        end
    end

    always_comb begin
        item_d = PMS_ITEM_OUTFREQ;
        case (pos_q)
            PMS_POS_FIRST: begin
                if (panel_monitor_select_setting_i == SEL_SETSTOP && stopped && !fault_i) begin
                    item_d = PMS_ITEM_SETFREQ;
                end else begin
                    item_d = PMS_ITEM_OUTFREQ;
                end
            end
            PMS_POS_SECOND: item_d = PMS_ITEM_CURRENT;
            PMS_POS_THIRD: begin
                if (term_sel) begin
                    item_d = PMS_ITEM_TERMINAL;
                end else if (panel_monitor_select_setting_i == SEL_VOLTAGE
                             || panel_monitor_select_setting_i == SEL_SETSTOP) begin
                    item_d = PMS_ITEM_VOLTAGE;
                end else if (panel_monitor_select_setting_i == SEL_RAWSET) begin
                    item_d = PMS_ITEM_RAWSET;
                end else if (panel_in_use_i) begin
                    item_d = PMS_ITEM_OTHER;
                end else begin
                    item_d = PMS_ITEM_VOLTAGE;
                end
            end
            default: item_d = PMS_ITEM_FAULT;
        endcase
    end

    always_comb begin
        case (item_d)
            PMS_ITEM_SETFREQ: value_d = set_lim;
            PMS_ITEM_RAWSET:  value_d = set_freq_raw_i;
            PMS_ITEM_CURRENT: value_d = current_i;
            PMS_ITEM_VOLTAGE: value_d = voltage_i;
            PMS_ITEM_OTHER:   value_d = other_value_i;
            PMS_ITEM_TERMINAL: value_d = '0;
            PMS_ITEM_FAULT:   value_d = fault_freq;
            default:          value_d = fault_i ? fault_freq : out_freq_i;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            item_o  <= PMS_ITEM_OUTFREQ;
            value_o <= '0;
        end else begin
            item_o  <= item_d;
            value_o <= value_d;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hz_led_o <= 1'b0;
        end else if (item_d == PMS_ITEM_SETFREQ) begin
            hz_led_o <= blink_q;
        end else begin
            hz_led_o <= (item_d == PMS_ITEM_OUTFREQ) || (item_d == PMS_ITEM_RAWSET);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seg_upper_o  <= '0;
            seg_lower_o  <= '0;
            seg_middle_o <= 1'b0;
            dp_o         <= 4'h0;
        end else if (item_d == PMS_ITEM_TERMINAL) begin
            seg_upper_o  <= up_d;
            seg_lower_o  <= lo_d;
            seg_middle_o <= mid_d;
            dp_o         <= dp_d;
        end else begin
            seg_upper_o  <= '0;
            seg_lower_o  <= '0;
            seg_middle_o <= 1'b0;
            dp_o         <= 4'h0;
        end
    end

    assign pos_o = pos_q;
endmodule // pms_top
